// ### logic/risc_alu.sv
//==========================================================
// eight bit arithmetic unit
//==========================================================
module risc_alu (
    input wire risc_core_pkg::alu_op_t op,
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    input wire logic [2:0] bit_sel,
    input wire logic carry_in,
    output risc_core_pkg::alu_out_t out
);
    import risc_core_pkg::*;

    // result and flags, a is the accumulator side
    always_comb begin
        logic [8:0] sum;
        logic [4:0] nib;
        sum = 9'h000;
        nib = 5'h00;
        out.result = b;
        out.carry = carry_in;
        out.digit_carry_flag = 1'b0;
        case (op)
            ALU_ADD: begin
                sum = {1'b0, a} + {1'b0, b};
                nib = {1'b0, a[3:0]} + {1'b0, b[3:0]};
            end
            ALU_SUB: begin
                // b minus a in two's complement, carry high means no borrow
                sum = {1'b0, b} + {1'b0, ~a} + 9'h001;
                nib = {1'b0, b[3:0]} + {1'b0, ~a[3:0]} + 5'h01;
            end
            ALU_AND: out.result = a & b;
            ALU_IOR: out.result = a | b;
            ALU_XOR: out.result = a ^ b;
            ALU_COM: out.result = ~b;
            ALU_INC: out.result = b + 8'h01;
            ALU_DEC: out.result = b - 8'h01;
            ALU_RLF: begin
                out.result = {b[6:0], carry_in};
                out.carry = b[7];
            end
            ALU_RRF: begin
                out.result = {carry_in, b[7:1]};
                out.carry = b[0];
            end
            ALU_SWAP: out.result = {b[3:0], b[7:4]};
            ALU_PASS_A: out.result = a;
            ALU_PASS_B: out.result = b;
            ALU_CLR: out.result = 8'h00;
            ALU_BCLR: out.result = b & ~(8'h01 << bit_sel);
            ALU_BSET: out.result = b | (8'h01 << bit_sel);
            default: out.result = b;
        endcase
        // add and subtract share the adder outputs
        if (op == ALU_ADD || op == ALU_SUB) begin
            out.result = sum[7:0];
            out.carry = sum[8];
            out.digit_carry_flag = nib[4];
        end
        out.zero = (out.result == 8'h00);
    end
endmodule : risc_alu

// ### logic/risc_core_alu_pipeline.sv
`include "risc_core_consts.svh"

//==========================================================
// core execution datapath
//==========================================================
// Overview of operation
// - fetch overlaps execute; branches take two cycles
// - one 14-bit instruction word fetched per cycle
// - eight-level hardware return-address stack
// - decoder implements thirty-five operations
// - eight-bit alu: add, subtract, shift, logic
// - arithmetic is two's complement
// - accumulator with file or literal operand
// - accumulator is 8-bit and not addressable
// - alu updates carry, digit carry, zero
// - subtraction flags are inverted borrow, set on no borrow
// - internal program memory of 512, 1K, 2K
// - special registers mapped, direct and indirect
// - any operation on any register
// - separate program and data buses
module risc_core_alu_pipeline #(
    parameter int PROG_AW = `RC_PROG_AW
) (
    input wire logic clk,
    input wire logic reset_n,
    output logic [PROG_AW-1:0] prog_addr,
    input wire logic [`RC_IW-1:0] prog_data,
    output risc_core_pkg::data_req_t data_req,
    input wire logic [7:0] data_rdata,
    output logic [7:0] w_value,
    output logic [7:0] status_value,
    output logic sleep_req,
    output logic wdt_clear
);
    import risc_core_pkg::*;

    logic [`RC_PC_W-1:0] pc, next_pc;
    logic [`RC_IW-1:0] ir, next_ir;
    logic [`RC_SP_W-1:0] sp, next_sp;
    logic [`RC_PC_W-1:0] stack [`RC_STACK_DEPTH];
    logic [7:0] w, next_w;
    logic [7:0] status, next_status;
    logic [7:0] fsr, next_fsr;
    logic [4:0] pclath, next_pclath;

    logic [3:0] alu_op; // plain bits so the decode may fill it by concatenation
    alu_out_t alu;
    logic use_lit, dest_w, dest_f, fl_c, fl_dc, fl_z;
    logic is_goto, is_call, is_ret, ret_lit, skip_zero, bit_test;
    logic [7:0] ea, file_rd, op_b;
    logic skip, sfr_hit, pcl_wr, flush;
    logic [`RC_PC_W-1:0] jump_target, stack_top;

    //======================================================
    // instruction decode
    //======================================================
    // separate program bus, one word per cycle
    assign prog_addr = pc[PROG_AW-1:0];

    // thirty-five operations, any register as operand
    always_comb begin
        alu_op = ALU_PASS_B;
        {use_lit, dest_w, dest_f, fl_c, fl_dc, fl_z} = 6'b000000;
        {is_goto, is_call, is_ret, ret_lit, skip_zero, bit_test} = 6'b000000;
        {sleep_req, wdt_clear} = 2'b00;
        case (ir[13:12])
            2'b00: begin
                dest_f = ir[7];
                dest_w = !ir[7];
                case (ir[11:8])
                    4'h0: begin
                        // move accumulator to file, or the no-operand group
                        alu_op = ALU_PASS_A;
                        dest_w = 1'b0;
                        is_ret = !ir[7] && (ir[6:0] == `RC_OP_RETURN
                            || ir[6:0] == `RC_OP_RETFIE);
                        sleep_req = !ir[7] && ir[6:0] == `RC_OP_SLEEP;
                        wdt_clear = !ir[7] && ir[6:0] == `RC_OP_CLRWDT;
                    end
                    4'h1: {alu_op, fl_z} = {ALU_CLR, 1'b1};
                    4'h2: {alu_op, fl_c, fl_dc, fl_z} = {ALU_SUB, 3'b111};
                    4'h3: {alu_op, fl_z} = {ALU_DEC, 1'b1};
                    4'h4: {alu_op, fl_z} = {ALU_IOR, 1'b1};
                    4'h5: {alu_op, fl_z} = {ALU_AND, 1'b1};
                    4'h6: {alu_op, fl_z} = {ALU_XOR, 1'b1};
                    4'h7: {alu_op, fl_c, fl_dc, fl_z} = {ALU_ADD, 3'b111};
                    4'h8: {alu_op, fl_z} = {ALU_PASS_B, 1'b1};
                    4'h9: {alu_op, fl_z} = {ALU_COM, 1'b1};
                    4'hA: {alu_op, fl_z} = {ALU_INC, 1'b1};
                    4'hB: {alu_op, skip_zero} = {ALU_DEC, 1'b1};
                    4'hC: {alu_op, fl_c} = {ALU_RRF, 1'b1};
                    4'hD: {alu_op, fl_c} = {ALU_RLF, 1'b1};
                    4'hE: alu_op = ALU_SWAP;
                    default: {alu_op, skip_zero} = {ALU_INC, 1'b1};
                endcase
            end
            2'b01: begin
                // bit clear, set, test
                alu_op = ir[10] ? ALU_BSET : ALU_BCLR;
                dest_f = !ir[11];
                bit_test = ir[11];
            end
            2'b10: begin
                is_goto = ir[11];
                is_call = !ir[11];
            end
            default: begin
                // literal group, result to accumulator
                use_lit = 1'b1;
                dest_w = 1'b1;
                case (ir[11:8])
                    4'h4, 4'h5, 4'h6, 4'h7: {is_ret, ret_lit} = 2'b11;
                    4'h8: {alu_op, fl_z} = {ALU_IOR, 1'b1};
                    4'h9: {alu_op, fl_z} = {ALU_AND, 1'b1};
                    4'hA: {alu_op, fl_z} = {ALU_XOR, 1'b1};
                    4'hB: dest_w = 1'b0;
                    4'hC, 4'hD: {alu_op, fl_c, fl_dc, fl_z} = {ALU_SUB, 3'b111};
                    4'hE, 4'hF: {alu_op, fl_c, fl_dc, fl_z} = {ALU_ADD, 3'b111};
                    default: alu_op = ALU_PASS_B;
                endcase
            end
        endcase
    end

    //======================================================
    // operand fetch and alu
    //======================================================
    // indirect through fsr when the file field is zero
    assign ea = (ir[6:0] == `RC_ADDR_INDF) ? fsr
        : {status[`RC_RP0_BIT], ir[6:0]};

    // special registers mirrored in both banks
    assign sfr_hit = (ea[6:0] == `RC_ADDR_INDF) || (ea[6:0] == `RC_ADDR_PCL)
        || (ea[6:0] == `RC_ADDR_STATUS) || (ea[6:0] == `RC_ADDR_FSR)
        || (ea[6:0] == `RC_ADDR_PCLATH);

    // read mux, the accumulator has no address
    always_comb begin
        file_rd = data_rdata;
        if (ea[6:0] == `RC_ADDR_INDF) begin
            file_rd = 8'h00;
        end else if (ea[6:0] == `RC_ADDR_PCL) begin
            file_rd = pc[7:0];
        end else if (ea[6:0] == `RC_ADDR_STATUS) begin
            file_rd = status;
        end else if (ea[6:0] == `RC_ADDR_FSR) begin
            file_rd = fsr;
        end else if (ea[6:0] == `RC_ADDR_PCLATH) begin
            file_rd = {3'h0, pclath};
        end
    end

    // accumulator against file or literal
    assign op_b = use_lit ? ir[7:0] : file_rd;

    risc_alu u_alu (
        .op(alu_op_t'(alu_op)),
        .a(w),
        .b(op_b),
        .bit_sel(ir[9:7]),
        .carry_in(status[`RC_C_BIT]),
        .out(alu)
    );

    // external file write, internal registers stay local
    assign data_req.we = dest_f && !sfr_hit;
    assign data_req.addr = ea;
    assign data_req.wdata = alu.result;

    //======================================================
    // pipeline control
    //======================================================
    assign skip = (skip_zero && alu.zero) || (bit_test && (op_b[ir[9:7]] == ir[10]));
    assign pcl_wr = dest_f && ea[6:0] == `RC_ADDR_PCL;
    assign jump_target = {pclath[4:3], ir[10:0]};
    assign stack_top = stack[sp - `RC_SP_W'(1)];
    assign flush = is_goto || is_call || is_ret || skip || pcl_wr;

    // next fetch address and stack pointer
    always_comb begin
        next_pc = pc + `RC_PC_W'(1);
        next_sp = sp;
        next_ir = flush ? `RC_NOP : prog_data;
        if (is_goto || is_call) begin
            next_pc = jump_target;
        end else if (is_ret) begin
            next_pc = stack_top;
        end else if (pcl_wr) begin
            next_pc = {pclath, alu.result};
        end
        if (is_call) begin
            next_sp = sp + `RC_SP_W'(1);
        end else if (is_ret) begin
            next_sp = sp - `RC_SP_W'(1);
        end
    end

    // fetch stage and return stack
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pc <= `RC_RESET_VECTOR;
            ir <= `RC_NOP;
            sp <= '0;
        end else begin
            pc <= next_pc;
            ir <= next_ir;
            sp <= next_sp;
        end
    end

    // stack storage, wraps after eight pushes
    always_ff @(posedge clk) begin
        if (is_call) begin
            stack[sp] <= pc;
        end
    end

    //======================================================
    // working registers and flags
    //======================================================
    always_comb begin
        next_w = w;
        next_status = status;
        next_fsr = fsr;
        next_pclath = pclath;
        if (dest_w) begin
            next_w = ret_lit ? ir[7:0] : alu.result;
        end
        if (dest_f && ea[6:0] == `RC_ADDR_STATUS) begin
            next_status = {alu.result[7:5], status[4:3], alu.result[2:0]};
        end
        if (dest_f && ea[6:0] == `RC_ADDR_FSR) begin
            next_fsr = alu.result;
        end
        if (dest_f && ea[6:0] == `RC_ADDR_PCLATH) begin
            next_pclath = alu.result[4:0];
        end
        // flag updates win over a direct write
        if (fl_c) begin
            next_status[`RC_C_BIT] = alu.carry;
        end
        if (fl_dc) begin
            next_status[`RC_DC_BIT] = alu.digit_carry_flag;
        end
        if (fl_z) begin
            next_status[`RC_Z_BIT] = alu.zero;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            w <= 8'h00;
            status <= `RC_STATUS_RST;
            fsr <= 8'h00;
            pclath <= 5'h00;
        end else begin
            w <= next_w;
            status <= next_status;
            fsr <= next_fsr;
            pclath <= next_pclath;
        end
    end

    assign w_value = w;
    assign status_value = status;

    //======================================================
    // checks
    //======================================================
    logic is_sub, is_add, lo_ge, add_ovf;
    assign is_sub = (alu_op == ALU_SUB) && fl_c;
    assign is_add = (alu_op == ALU_ADD) && fl_c;
    assign lo_ge = op_b[3:0] >= w[3:0];
    assign add_ovf = ({1'b0, w} + {1'b0, op_b}) > 9'h0FF;

    // checks wait one edge after release, the release edge itself still resets
    logic check_run;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            check_run <= 1'b0;
        end else begin
            check_run <= 1'b1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n || !check_run);

    AST_JUMP_TWO_CYCLE: assert property ((is_goto || is_call) |=>
        (pc == $past(jump_target) && ir == `RC_NOP))
        else $error("jump did not load target and flush");
    AST_SEQ_FETCH: assert property (!flush |=>
        (ir == $past(prog_data) && pc == $past(pc) + `RC_PC_W'(1)))
        else $error("sequential fetch broken");
    AST_SKIP_FLUSH: assert property ((skip && !is_ret) |=>
        (ir == `RC_NOP && pc == $past(pc) + `RC_PC_W'(1)))
        else $error("skip did not discard fetched word");
    AST_CALL_PUSH: assert property (is_call |=>
        (sp == $past(sp) + `RC_SP_W'(1) && stack[$past(sp)] == $past(pc)))
        else $error("call did not push return address");
    AST_RET_POP: assert property (is_ret |=> pc == $past(stack_top))
        else $error("return did not pop stack");
    AST_W_LOAD: assert property ((dest_w && !ret_lit) |=> w == $past(alu.result))
        else $error("accumulator not loaded");
    AST_ZERO_FLAG: assert property (fl_z |=>
        status[`RC_Z_BIT] == ($past(alu.result) == 8'h00))
        else $error("zero flag wrong");
    AST_SUB_BORROW: assert property (is_sub |=>
        (status[`RC_C_BIT] == ($past(op_b) >= $past(w)) && status[`RC_DC_BIT] == $past(lo_ge)))
        else $error("borrow flags wrong");
    AST_ADD_CARRY: assert property (is_add |=> status[`RC_C_BIT] == $past(add_ovf))
        else $error("add carry wrong");

    COV_CALL_RET: cover property (is_call ##[1:20] is_ret);
    COV_SKIP: cover property (skip);
    COV_BORROW: cover property (is_sub ##1 !status[`RC_C_BIT]);
    COV_PCL_WRITE: cover property (pcl_wr);
endmodule : risc_core_alu_pipeline

// ### pkg/risc_core_consts.svh
`ifndef RISC_CORE_CONSTS_SVH
`define RISC_CORE_CONSTS_SVH

//==========================================================
// widths and depths
//==========================================================
`define RC_IW 14
`define RC_PC_W 13
`define RC_PROG_AW 11
`define RC_STACK_DEPTH 8
`define RC_SP_W 3

//==========================================================
// fixed encodings and reset values
//==========================================================
`define RC_NOP 14'h0000
`define RC_RESET_VECTOR 13'h0000
`define RC_STATUS_RST 8'h18
`define RC_OP_RETURN 7'h08
`define RC_OP_RETFIE 7'h09
`define RC_OP_SLEEP 7'h63
`define RC_OP_CLRWDT 7'h64

//==========================================================
// special function register addresses, low seven bits
//==========================================================
`define RC_ADDR_INDF 7'h00
`define RC_ADDR_PCL 7'h02
`define RC_ADDR_STATUS 7'h03
`define RC_ADDR_FSR 7'h04
`define RC_ADDR_PCLATH 7'h0A

//==========================================================
// status bit positions
//==========================================================
`define RC_C_BIT 0
`define RC_DC_BIT 1
`define RC_Z_BIT 2
`define RC_RP0_BIT 5

`endif

// ### pkg/risc_core_pkg.sv
//==========================================================
// shared types
//==========================================================
package risc_core_pkg;
    // alu operations
    typedef enum logic [3:0] {
        ALU_ADD, ALU_SUB, ALU_AND, ALU_IOR, ALU_XOR, ALU_COM, ALU_INC, ALU_DEC,
        ALU_RLF, ALU_RRF, ALU_SWAP, ALU_PASS_A, ALU_PASS_B, ALU_CLR, ALU_BCLR, ALU_BSET
    } alu_op_t;

    // alu result with flags
    typedef struct packed {
        logic [7:0] result;
        logic carry;
        logic digit_carry_flag;
        logic zero;
    } alu_out_t;

    // request to the data register file
    typedef struct packed {
        logic we;
        logic [7:0] addr;
        logic [7:0] wdata;
    } data_req_t;
endpackage : risc_core_pkg

// ### test/risc_mem_model.sv
//==========================================================
// program memory and data register file
//==========================================================
module risc_mem_model #(
    parameter int PROG_AW = 11
) (
    input wire logic clk,
    input wire logic [PROG_AW-1:0] prog_addr,
    output logic [13:0] prog_data,
    input wire risc_core_pkg::data_req_t data_req,
    output logic [7:0] data_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    import risc_core_pkg::*;

    // program words, loaded by the bench while the core is held in reset
    logic [13:0] rom [0:(2**PROG_AW)-1];
    logic [7:0] ram [0:255];

    // fill with a pattern, non-zero except at address A5, so cleared cells are visible
    initial begin
        for (int i = 0; i < 256; i++) begin
            ram[i] = 8'(i) ^ 8'hA5;
        end
    end

    // combinational reads on two separate buses
    assign prog_data = rom[prog_addr];
    assign data_rdata = ram[data_req.addr];

    // file write at the edge closing a write cycle
    always @(posedge clk) begin
        if (data_req.we) begin
            ram[data_req.addr] <= data_req.wdata;
        end
    end
endmodule : risc_mem_model

// ### test/tb_risc_core_alu_pipeline.sv
//==========================================================
// self-checking bench for the execution datapath
//==========================================================
module tb_risc_core_alu_pipeline;
    timeunit 1ns;
    timeprecision 1ps;
    import risc_core_pkg::*;

    // opcode bases of the fourteen bit word
    localparam logic [13:0] OP_MOVLW = 14'h3000;
    localparam logic [13:0] OP_ADDLW = 14'h3E00;
    localparam logic [13:0] OP_SUBLW = 14'h3C00;
    localparam logic [13:0] OP_ANDLW = 14'h3900;
    localparam logic [13:0] OP_IORLW = 14'h3800;
    localparam logic [13:0] OP_XORLW = 14'h3A00;
    localparam logic [13:0] OP_GOTO = 14'h2800;
    localparam logic [13:0] OP_CALL = 14'h2000;
    localparam logic [13:0] OP_RETURN = 14'h0008;
    localparam logic [13:0] OP_MOVWF = 14'h0080;
    localparam logic [13:0] OP_ADDWF_F = 14'h0780;
    localparam logic [13:0] OP_RLF_F = 14'h0D80;
    localparam logic [13:0] OP_INCF_W = 14'h0A00;
    localparam logic [13:0] OP_CLRF = 14'h0180;
    localparam logic [13:0] OP_MOVF_W = 14'h0800;
    localparam logic [13:0] OP_SLEEP = 14'h0063;
    localparam logic [13:0] OP_CLRWDT = 14'h0064;
    localparam logic [13:0] OP_BTFSS = 14'h1C00;

    logic clk;
    logic reset_n;
    logic [10:0] prog_addr;
    logic [13:0] prog_data;
    data_req_t data_req;
    logic [7:0] data_rdata;
    logic [7:0] w_value;
    logic [7:0] status_value;
    logic sleep_req;
    logic wdt_clear;
    int n_fail = 0;
    int checks = 0;

    risc_core_alu_pipeline #(.PROG_AW(11)) u_risc_core_alu_pipeline (
        .clk(clk), .reset_n(reset_n), .prog_addr(prog_addr), .prog_data(prog_data),
        .data_req(data_req), .data_rdata(data_rdata), .w_value(w_value),
        .status_value(status_value), .sleep_req(sleep_req), .wdt_clear(wdt_clear)
    );

    risc_mem_model #(.PROG_AW(11)) u_risc_mem_model (
        .clk(clk), .prog_addr(prog_addr), .prog_data(prog_data),
        .data_req(data_req), .data_rdata(data_rdata)
    );

    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    //==========================================================
    // shared tasks
    //==========================================================
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask : check

    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : wrap_up

    // hold the core in reset and blank the program
    task automatic restart();
        @(posedge clk);
        reset_n <= 1'b0;
        for (int i = 0; i < 2048; i++) begin
            u_risc_mem_model.rom[i] = 14'h0000;
        end
    endtask : restart

    task automatic load(input int a, input logic [13:0] word);
        u_risc_mem_model.rom[a] = word;
    endtask : load

    // release reset and run a number of cycles
    task automatic go(input int n);
        @(posedge clk);
        reset_n <= 1'b1;
        repeat (n) @(posedge clk);
        #1;
    endtask : go

    //==========================================================
    // scenarios
    //==========================================================
    task automatic test_reset();
        restart();
        @(posedge clk);
        #1;
        check("prog_addr", 16'(prog_addr), 16'h0000);
        check("w_value", 16'(w_value), 16'h0000);
        check("status_value", 16'(status_value), 16'h0018);
        check("data_we", 16'(data_req.we), 16'h0000);
        $display("test reset done");
    endtask : test_reset

    // literal operations, flags from a clean status
    task automatic test_alu();
        logic [13:0] op [8] = '{OP_ADDLW, OP_ADDLW, OP_SUBLW, OP_SUBLW,
                                OP_SUBLW, OP_ANDLW, OP_IORLW, OP_XORLW};
        logic [7:0] a [8] = '{8'hFF, 8'h08, 8'h05, 8'h03, 8'h05, 8'hF0, 8'h50, 8'hFF};
        logic [7:0] k [8] = '{8'h01, 8'h08, 8'h03, 8'h05, 8'h05, 8'h0F, 8'h0A, 8'hFF};
        logic [7:0] ew [8] = '{8'h00, 8'h10, 8'hFE, 8'h02, 8'h00, 8'h00, 8'h5A, 8'h00};
        logic [7:0] es [8] = '{8'h1F, 8'h1A, 8'h18, 8'h1B, 8'h1F, 8'h1C, 8'h18, 8'h1C};
        for (int i = 0; i < 8; i++) begin
            restart();
            load(0, OP_MOVLW | 14'(a[i]));
            load(1, op[i] | 14'(k[i]));
            load(2, OP_GOTO | 14'h0002);
            go(6);
            check("alu result", 16'(w_value), 16'(ew[i]));
            check("alu flags", 16'(status_value), 16'(es[i]));
        end
        $display("test alu done");
    endtask : test_alu

    // a taken branch costs one dead cycle, the skipped word never runs
    task automatic test_branch();
        logic [10:0] exp_pc [4] = '{11'h001, 11'h002, 11'h005, 11'h006};
        restart();
        load(0, OP_MOVLW | 14'h0001);
        load(1, OP_GOTO | 14'h0005);
        load(2, OP_MOVLW | 14'h00EE);
        load(5, OP_ADDLW | 14'h0001);
        load(6, OP_GOTO | 14'h0006);
        @(posedge clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            #1;
            check("prog_addr", 16'(prog_addr), 16'(exp_pc[i]));
        end
        check("w_value", 16'(w_value), 16'h0001);
        @(posedge clk);
        #1;
        check("w_value", 16'(w_value), 16'h0002);
        $display("test branch done");
    endtask : test_branch

    // file register operations through the data bus
    task automatic test_file();
        restart();
        u_risc_mem_model.ram[8'h21] = 8'h5C;
        load(0, OP_MOVLW | 14'h0021);
        load(1, OP_MOVWF | 14'h0020);
        load(2, OP_ADDWF_F | 14'h0020);
        load(3, OP_RLF_F | 14'h0020);
        load(4, OP_INCF_W | 14'h0020);
        load(5, OP_CLRF | 14'h0021);
        load(6, OP_GOTO | 14'h0006);
        go(10);
        check("file 20", 16'(u_risc_mem_model.ram[8'h20]), 16'h0084);
        check("file 21", 16'(u_risc_mem_model.ram[8'h21]), 16'h0000);
        check("w_value", 16'(w_value), 16'h0085);
        check("status_value", 16'(status_value), 16'h001C);
        $display("test file done");
    endtask : test_file

    // indirect access, internal registers stay off the bus
    task automatic test_indirect();
        restart();
        u_risc_mem_model.ram[8'h04] = 8'h3C;
        u_risc_mem_model.ram[8'h25] = 8'h00;
        load(0, OP_MOVLW | 14'h0025);
        load(1, OP_MOVWF | 14'h0004);
        load(2, OP_MOVLW | 14'h0099);
        load(3, OP_MOVWF | 14'h0000);
        load(4, OP_MOVLW | 14'h0000);
        load(5, OP_MOVF_W | 14'h0000);
        load(6, OP_GOTO | 14'h0006);
        go(10);
        check("file 25", 16'(u_risc_mem_model.ram[8'h25]), 16'h0099);
        check("file 04", 16'(u_risc_mem_model.ram[8'h04]), 16'h003C);
        check("w_value", 16'(w_value), 16'h0099);
        $display("test indirect done");
    endtask : test_indirect

    // eight nested calls, each return adds one
    task automatic test_stack();
        restart();
        load(0, OP_CALL | 14'h0010);
        load(1, OP_ADDLW | 14'h0001);
        load(2, OP_GOTO | 14'h0002);
        for (int i = 1; i < 8; i++) begin
            load(i * 16, OP_CALL | 14'((i + 1) * 16));
            load(i * 16 + 1, OP_ADDLW | 14'h0001);
            load(i * 16 + 2, OP_RETURN);
        end
        load(128, OP_RETURN);
        go(60);
        check("w_value", 16'(w_value), 16'h0008);
        $display("test stack done");
    endtask : test_stack

    // sleep and watchdog pulses, then a bit test that skips one word
    task automatic test_misc();
        restart();
        load(0, OP_SLEEP);
        load(1, OP_CLRWDT);
        load(2, OP_MOVLW | 14'h0001);
        load(3, OP_XORLW | 14'h0001);
        load(4, OP_BTFSS | 14'h0103);
        load(5, OP_MOVLW | 14'h00EE);
        load(6, OP_ADDLW | 14'h0005);
        load(7, OP_GOTO | 14'h0007);
        @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        #1;
        check("sleep_req", 16'(sleep_req), 16'h0001);
        check("wdt_clear", 16'(wdt_clear), 16'h0000);
        @(posedge clk);
        #1;
        check("sleep_req", 16'(sleep_req), 16'h0000);
        check("wdt_clear", 16'(wdt_clear), 16'h0001);
        repeat (10) @(posedge clk);
        #1;
        check("w_value", 16'(w_value), 16'h0005);
        check("status_value", 16'(status_value), 16'h0018);
        $display("test misc done");
    endtask : test_misc

    //==========================================================
    // main sequence and watchdog
    //==========================================================
    initial begin
        reset_n = 1'b0;
        repeat (16) @(posedge clk);
        test_reset();
        test_alu();
        test_branch();
        test_file();
        test_indirect();
        test_stack();
        test_misc();
        wrap_up();
    end

    // tests need well under a thousand cycles
    initial begin
        repeat (3000) @(posedge clk);
        n_fail++;
        wrap_up();
    end
endmodule : tb_risc_core_alu_pipeline
